// File: logic/cgt_pkg.sv
// constants, types and register map of the counter gate, arming and totalize control
// assumes one 200 MHz clock and software access over apb
package cgt_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  localparam int unsigned SHORT_MAX_MS = 20;
  localparam int unsigned STD_MAX_S = 4;
  // holdoff and gate lengths are counted in timebase ticks of TICK_US
  localparam logic [15:0] SHORT_MIN_TK = 16'h0001;
  localparam logic [15:0] SHORT_MAX_TK = 16'((SHORT_MAX_MS * 1000) / TICK_US);
  localparam logic [15:0] STD_MIN_TK = SHORT_MAX_TK;
  localparam logic [15:0] STD_MAX_TK = 16'((STD_MAX_S * 1000000) / TICK_US);
  localparam logic [15:0] GATE_TK_RST = 16'h2710;
  localparam logic [7:0] TAG_CHAR = 8'h54;
  localparam logic [7:0] TAG_NONE = 8'h00;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_GATE = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_RES_A = 8'h10;
  localparam logic [7:0] OFF_RES_B = 8'h14;
  localparam int unsigned CMD_KEY = 0;
  localparam int unsigned CMD_CLR = 1;
  localparam int unsigned STAT_OPEN = 0;
  localparam int unsigned STAT_DELAY = 1;
  localparam int unsigned STAT_OPS = 2;
  localparam int unsigned STAT_FSM = 3;

  typedef enum logic [1:0] {
    FN_FREQ = 2'h0,
    FN_INTERVAL = 2'h1,
    FN_TOTAL = 2'h2,
    FN_RATIO = 2'h3
  } cgt_func_t;

  typedef enum logic [1:0] {
    GM_STANDARD = 2'h0,
    GM_SHORT = 2'h1,
    GM_SINGLE = 2'h2,
    GM_KEY = 2'h3
  } cgt_gmode_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARMED = 5'h02,
    ST_OPEN = 5'h04,
    ST_DONE = 5'h10
  } cgt_fsm_t;

  typedef struct packed {
    logic arith_post_op;
    logic running_average_op;
    logic ch2_fall;
    logic ch1_fall;
    logic repeat_single;
    logic outside_arming_switch;
    logic stop_arm_en;
    logic stop_fall;
    logic start_fall;
    cgt_gmode_t gmode;
    cgt_func_t func;
  } cgt_ctrl_t;

  localparam int unsigned CTRL_W = $bits(cgt_ctrl_t);
  localparam cgt_ctrl_t CTRL_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                     GM_STANDARD, FN_FREQ};

  typedef struct packed {
    logic valid;
    logic [7:0] tag;
    logic [31:0] data;
  } cgt_host_t;

  typedef struct packed {
    cgt_ctrl_t ctrl;
    logic [15:0] gate_tk;
    cgt_fsm_t fsm;
    logic [31:0] tick_cnt;
    logic tick;
    logic [15:0] timer;
    logic close_armed;
    logic [1:0] edges;
    logic key_open;
    logic reported;
    logic div_ff;
    logic [31:0] cnt_a;
    logic [31:0] cnt_b;
    logic [31:0] res_a;
    logic [31:0] res_b;
    logic [31:0] fly_prev;
    logic [31:0] fly_sent;
    logic ch1_q;
    logic ch2_q;
    logic arm_q;
    cgt_host_t host;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic gate_n;
    logic delay_led;
    logic [1:0] ops_en;
  } cgt_state_t;
endpackage

// File: logic/cgt_gate_ctrl.sv
// gate, arming and measurement-mode control of a universal counter, with its apb register file
// assumes conditioned channel inputs and arming input synchronous to mclk_i
// Functional notes
// - power-up selects frequency function, standard gate
// - channel one prescaled by two, full resolution
// - no outside arming: self-arm and run at once
// - outside arming: opening and closing on chosen edges
// - closing arm off: standard and short gate ended by gate timer
// - single-cycle gate spans two input periods with closing arm off
// - interval runs from channel one to channel two
// - entering interval turns standard gate into single-cycle
// - interval non-single gate: hold off stop, light delay
// - holdoff ranges differ for short and standard gate
// - entering totalize turns standard gate into key gate, gate closed
// - key toggles gate, reopening keeps the total
// - reset command clears total in any gate state
// - automatic totalize clears count between measurements
// - running average and arithmetic off in key totalize
// - totalize result sent only after gate closes
// - key gate single repeat sends running totals
// - running total sent only on two equal reads
// - closing total tagged, running totals untagged
// - ratio reports channel one over channel two counts
// - closing arm enable forces single-cycle gate mode
// - timer after opening arm, then closing edge arms
`timescale 1ns/1ps
module cgt_gate_ctrl #(
  parameter int unsigned TICK_CYCLES = cgt_pkg::TICK_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ch1_i,
  input wire logic ch2_i,
  input wire logic arm_i,
  output logic gate_n_o,
  output logic delay_led_o,
  output logic [1:0] ops_en_o,
  output cgt_pkg::cgt_host_t host_o
);
  cgt_pkg::cgt_state_t q;
  cgt_pkg::cgt_state_t d;
  cgt_pkg::cgt_ctrl_t nc;
  logic e1, e2, sa, so, sync_e, manual, ext_stop, ext, tmo, acc, wr, kp, clr, fly, ops_ok;
  logic [31:0] full_a;
  logic [31:0] rdata;

  function automatic logic qual_edge(input logic cur, input logic prev, input logic fall);
    qual_edge = fall ? (prev & ~cur) : (cur & ~prev);
  endfunction

  function automatic logic [15:0] hold_len(input cgt_pkg::cgt_gmode_t gm, input logic [15:0] tk);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = (gm == cgt_pkg::GM_SHORT) ? cgt_pkg::SHORT_MIN_TK : cgt_pkg::STD_MIN_TK;
    hi = (gm == cgt_pkg::GM_SHORT) ? cgt_pkg::SHORT_MAX_TK : cgt_pkg::STD_MAX_TK;
    hold_len = (tk < lo) ? lo : ((tk > hi) ? hi : tk);
  endfunction

  function automatic logic [15:0] gate_len(input logic [15:0] tk);
    gate_len = (tk == 16'h0000) ? 16'h0001 : tk;
  endfunction

  always_comb begin
    d = q;
    d.host.valid = 1'b0;
    d.tick = 1'b0;
    // timebase tick and gate timer
    if (q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      d.tick_cnt = 32'h0000_0000;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 32'h0000_0001;
    end
    if (q.tick && q.timer != 16'h0000) begin
      d.timer = q.timer - 16'h0001;
    end
    tmo = (q.timer == 16'h0000);
    e1 = qual_edge(ch1_i, q.ch1_q, q.ctrl.ch1_fall);
    e2 = qual_edge(ch2_i, q.ch2_q, q.ctrl.ch2_fall);
    sa = qual_edge(arm_i, q.arm_q, q.ctrl.start_fall);
    so = qual_edge(arm_i, q.arm_q, q.ctrl.stop_fall);
    d.ch1_q = ch1_i;
    d.ch2_q = ch2_i;
    d.arm_q = arm_i;
    sync_e = (q.ctrl.func == cgt_pkg::FN_RATIO) ? e2 : e1;
    manual = (q.ctrl.gmode == cgt_pkg::GM_KEY) && (q.ctrl.func != cgt_pkg::FN_INTERVAL);
    ext = q.ctrl.outside_arming_switch;
    ext_stop = ext && q.ctrl.stop_arm_en;
    fly = (q.ctrl.func == cgt_pkg::FN_TOTAL) && manual && q.ctrl.repeat_single;
    full_a = {q.cnt_a[30:0], q.div_ff};
    // apb: one wait state, write takes effect when pready is high, read data is taken in the wait state
    acc = psel_i && penable_i;
    wr = acc && pwrite_i && q.pready;
    kp = wr && (paddr_i == cgt_pkg::OFF_CMD) && pwdata_i[cgt_pkg::CMD_KEY];
    clr = wr && (paddr_i == cgt_pkg::OFF_CMD) && pwdata_i[cgt_pkg::CMD_CLR];
    nc = cgt_pkg::cgt_ctrl_t'(pwdata_i[cgt_pkg::CTRL_W-1:0]);
    ops_ok = !((q.ctrl.func == cgt_pkg::FN_TOTAL) && (q.ctrl.gmode == cgt_pkg::GM_KEY));
    rdata = 32'h0000_0000;
    case (paddr_i)
      cgt_pkg::OFF_CTRL: rdata = 32'(q.ctrl);
      cgt_pkg::OFF_GATE: rdata = {16'h0000, q.gate_tk};
      cgt_pkg::OFF_STAT: begin
        rdata[cgt_pkg::STAT_OPEN] = !q.gate_n;
        rdata[cgt_pkg::STAT_DELAY] = q.delay_led;
        rdata[cgt_pkg::STAT_OPS] = ops_ok;
        rdata[cgt_pkg::STAT_FSM +: 5] = q.fsm;
      end
      cgt_pkg::OFF_RES_A: rdata = q.res_a;
      cgt_pkg::OFF_RES_B: rdata = q.res_b;
      default: rdata = 32'h0000_0000;
    endcase
    d.pready = acc && !q.pready;
    if (acc && !q.pready) begin
      d.prdata = rdata;
      d.pslverr = !(paddr_i == cgt_pkg::OFF_CTRL || paddr_i == cgt_pkg::OFF_GATE ||
                    paddr_i == cgt_pkg::OFF_CMD || paddr_i == cgt_pkg::OFF_STAT ||
                    paddr_i == cgt_pkg::OFF_RES_A || paddr_i == cgt_pkg::OFF_RES_B);
    end
    if (kp && manual) begin
      d.key_open = !q.key_open;
    end
    case (q.fsm)
      cgt_pkg::ST_IDLE: begin
        d.close_armed = 1'b0;
        d.edges = 2'h0;
        d.reported = 1'b0;
        if (manual) begin
          if (d.key_open) begin
            // a reopened totalize gate keeps adding to the total
            if (q.ctrl.func != cgt_pkg::FN_TOTAL) begin
              d.cnt_a = 32'h0000_0000;
              d.cnt_b = 32'h0000_0000;
              d.div_ff = 1'b0;
            end
            d.fly_sent = 32'hffff_ffff;
            d.fsm = cgt_pkg::ST_OPEN;
          end
        end else if (!ext || sa) begin
          d.cnt_a = 32'h0000_0000;
          d.cnt_b = 32'h0000_0000;
          d.div_ff = 1'b0;
          d.fsm = cgt_pkg::ST_ARMED;
          if (ext_stop && q.ctrl.gmode != cgt_pkg::GM_SINGLE) begin
            d.timer = gate_len(q.gate_tk);
          end
        end
      end
      cgt_pkg::ST_ARMED: begin
        if (q.ctrl.func == cgt_pkg::FN_INTERVAL) begin
          if (e1) begin
            d.cnt_b = 32'h0000_0000;
            d.timer = (q.ctrl.gmode == cgt_pkg::GM_SINGLE) ? 16'h0000 : hold_len(q.ctrl.gmode, q.gate_tk);
            d.fsm = cgt_pkg::ST_OPEN;
          end
        end else if (sync_e) begin
          if (!ext_stop) begin
            d.timer = gate_len(q.gate_tk);
          end
          d.fsm = cgt_pkg::ST_OPEN;
        end
      end
      cgt_pkg::ST_OPEN: begin
        if (q.ctrl.func == cgt_pkg::FN_INTERVAL) begin
          d.cnt_b = q.cnt_b + 32'h0000_0001;
          // stop edges are ignored while the holdoff timer runs
          if (e2 && (q.ctrl.gmode == cgt_pkg::GM_SINGLE || tmo)) begin
            d.fsm = cgt_pkg::ST_DONE;
          end
        end else begin
          if (e1) begin
            d.div_ff = !q.div_ff;
            if (q.div_ff) begin
              d.cnt_a = q.cnt_a + 32'h0000_0001;
            end
          end
          if (e2 && q.ctrl.func == cgt_pkg::FN_RATIO) begin
            d.cnt_b = q.cnt_b + 32'h0000_0001;
          end
          if (manual) begin
            if (!d.key_open) begin
              d.fsm = cgt_pkg::ST_DONE;
            end
          end else begin
            if (ext_stop && so && (q.ctrl.gmode == cgt_pkg::GM_SINGLE || tmo)) begin
              d.close_armed = 1'b1;
            end else if (!ext_stop && q.ctrl.gmode != cgt_pkg::GM_SINGLE && tmo) begin
              d.close_armed = 1'b1;
            end
            if (sync_e) begin
              d.edges = q.edges + 2'h1;
              if (q.close_armed ||
                  (q.ctrl.gmode == cgt_pkg::GM_SINGLE && !ext_stop && q.edges == 2'h1)) begin
                d.fsm = cgt_pkg::ST_DONE;
              end
            end
          end
          if (fly && q.tick) begin
            d.fly_prev = full_a;
            if (full_a == q.fly_prev && full_a != q.fly_sent) begin
              d.fly_sent = full_a;
              d.host = '{1'b1, cgt_pkg::TAG_NONE, full_a};
            end
          end
        end
      end
      cgt_pkg::ST_DONE: begin
        if (!q.reported) begin
          d.reported = 1'b1;
          d.res_a = (q.ctrl.func == cgt_pkg::FN_INTERVAL) ? q.cnt_b : full_a;
          d.res_b = q.cnt_b;
          d.host.valid = 1'b1;
          d.host.tag = (q.ctrl.func == cgt_pkg::FN_TOTAL) ? cgt_pkg::TAG_CHAR : cgt_pkg::TAG_NONE;
          d.host.data = (q.ctrl.func == cgt_pkg::FN_INTERVAL) ? q.cnt_b : full_a;
        end else if (manual || !q.ctrl.repeat_single) begin
          d.fsm = cgt_pkg::ST_IDLE;
        end
      end
      default: d.fsm = cgt_pkg::ST_IDLE;
    endcase
    if (wr && paddr_i == cgt_pkg::OFF_CTRL) begin
      d.ctrl = nc;
      if (nc.func != q.ctrl.func && nc.func == cgt_pkg::FN_INTERVAL && nc.gmode == cgt_pkg::GM_STANDARD) begin
        d.ctrl.gmode = cgt_pkg::GM_SINGLE;
      end
      if (nc.func != q.ctrl.func && nc.func == cgt_pkg::FN_TOTAL && nc.gmode == cgt_pkg::GM_STANDARD) begin
        d.ctrl.gmode = cgt_pkg::GM_KEY;
      end
      if (nc.stop_arm_en && !q.ctrl.stop_arm_en) begin
        d.ctrl.gmode = cgt_pkg::GM_SINGLE;
      end
      d.fsm = cgt_pkg::ST_IDLE;
      d.key_open = 1'b0;
      d.close_armed = 1'b0;
    end
    if (wr && paddr_i == cgt_pkg::OFF_GATE) begin
      d.gate_tk = pwdata_i[15:0];
    end
    if (clr) begin
      // clearing leaves the gate where it is, a halted single run restarts
      d.cnt_a = 32'h0000_0000;
      d.cnt_b = 32'h0000_0000;
      d.div_ff = 1'b0;
      d.fly_prev = 32'h0000_0000;
      d.fly_sent = 32'hffff_ffff;
      d.res_a = 32'h0000_0000;
      d.res_b = 32'h0000_0000;
      if (q.fsm == cgt_pkg::ST_DONE && q.reported) begin
        d.fsm = cgt_pkg::ST_IDLE;
      end
    end
    d.gate_n = (d.fsm != cgt_pkg::ST_OPEN);
    d.delay_led = (d.ctrl.func == cgt_pkg::FN_INTERVAL) && (d.ctrl.gmode != cgt_pkg::GM_SINGLE);
    d.ops_en = {d.ctrl.arith_post_op, d.ctrl.running_average_op} &
               {2{!((d.ctrl.func == cgt_pkg::FN_TOTAL) && (d.ctrl.gmode == cgt_pkg::GM_KEY))}};
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.ctrl <= cgt_pkg::CTRL_RST;
      q.gate_tk <= cgt_pkg::GATE_TK_RST;
      q.fsm <= cgt_pkg::ST_IDLE;
      q.fly_sent <= 32'hffff_ffff;
      q.gate_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign gate_n_o = q.gate_n;
  assign delay_led_o = q.delay_led;
  assign ops_en_o = q.ops_en;
  assign host_o = q.host;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  a_reset_mode_default: assert property (!$past(nrst_i) |->
    q.ctrl.func == cgt_pkg::FN_FREQ && q.ctrl.gmode == cgt_pkg::GM_STANDARD && gate_n_o)
    else $error("reset did not select frequency with standard gate");
  a_self_arm_now: assert property (q.fsm == cgt_pkg::ST_IDLE && !ext && !manual && !wr |=>
    q.fsm == cgt_pkg::ST_ARMED)
    else $error("self arming did not start");
  a_single_two_edges: assert property (q.fsm == cgt_pkg::ST_OPEN && q.ctrl.func == cgt_pkg::FN_FREQ &&
    q.ctrl.gmode == cgt_pkg::GM_SINGLE && !ext_stop && sync_e && q.edges == 2'h0 && !wr |=>
    q.fsm == cgt_pkg::ST_OPEN)
    else $error("single cycle gate closed after one period");
  a_interval_to_single: assert property (wr && paddr_i == cgt_pkg::OFF_CTRL &&
    nc.func == cgt_pkg::FN_INTERVAL && q.ctrl.func != cgt_pkg::FN_INTERVAL &&
    nc.gmode == cgt_pkg::GM_STANDARD |=> q.ctrl.gmode == cgt_pkg::GM_SINGLE ##1 !delay_led_o)
    else $error("interval entry kept standard gate");
  a_holdoff_blocks_stop: assert property (q.fsm == cgt_pkg::ST_OPEN && q.ctrl.func == cgt_pkg::FN_INTERVAL &&
    q.ctrl.gmode != cgt_pkg::GM_SINGLE && q.timer != 16'h0000 && !wr |=> q.fsm != cgt_pkg::ST_DONE && delay_led_o)
    else $error("stop channel not held off");
  a_short_hold_range: assert property ($rose(q.fsm == cgt_pkg::ST_OPEN) &&
    q.ctrl.func == cgt_pkg::FN_INTERVAL && q.ctrl.gmode == cgt_pkg::GM_SHORT |->
    q.timer >= cgt_pkg::SHORT_MIN_TK && q.timer <= cgt_pkg::SHORT_MAX_TK)
    else $error("short holdoff out of range");
  a_total_to_key: assert property (wr && paddr_i == cgt_pkg::OFF_CTRL && nc.func == cgt_pkg::FN_TOTAL &&
    q.ctrl.func != cgt_pkg::FN_TOTAL && nc.gmode == cgt_pkg::GM_STANDARD && !nc.stop_arm_en |=>
    q.ctrl.gmode == cgt_pkg::GM_KEY && q.fsm == cgt_pkg::ST_IDLE ##1 gate_n_o && ops_en_o == 2'h0)
    else $error("totalize entry not key gated and closed");
  a_key_closes_gate: assert property (q.fsm == cgt_pkg::ST_OPEN && manual && q.key_open && kp &&
    !clr |=> q.fsm == cgt_pkg::ST_DONE ##1 host_o.valid)
    else $error("key press did not close gate");
  a_clear_any_state: assert property (clr && !kp && !(wr && paddr_i == cgt_pkg::OFF_CTRL) |=>
    q.cnt_a == 32'h0000_0000 && !q.div_ff && $stable(q.key_open))
    else $error("reset command did not clear total");
  a_tagged_after_close: assert property (host_o.valid && host_o.tag == cgt_pkg::TAG_CHAR |->
    $past(q.fsm) == cgt_pkg::ST_DONE && q.ctrl.func == cgt_pkg::FN_TOTAL)
    else $error("tagged total sent before gate closed");
  a_running_untagged: assert property (host_o.valid && $past(q.fsm) == cgt_pkg::ST_OPEN |->
    host_o.tag == cgt_pkg::TAG_NONE && host_o.data == $past(q.fly_prev))
    else $error("running total tagged or unstable");
  a_stop_arm_single: assert property (wr && paddr_i == cgt_pkg::OFF_CTRL && nc.stop_arm_en &&
    !q.ctrl.stop_arm_en |=> q.ctrl.gmode == cgt_pkg::GM_SINGLE)
    else $error("closing arm did not force single cycle");
  a_apb_one_wait: assert property (acc && !q.pready |=> pready_o ##1 !pready_o)
    else $error("apb answer not a single cycle pulse");

  c_freq_done: cover property (q.fsm == cgt_pkg::ST_DONE && q.ctrl.func == cgt_pkg::FN_FREQ);
  c_interval_hold: cover property (q.fsm == cgt_pkg::ST_OPEN && delay_led_o ##1 q.fsm == cgt_pkg::ST_DONE);
  c_fly_send: cover property (host_o.valid && host_o.tag == cgt_pkg::TAG_NONE && fly);
  c_total_reopen: cover property (q.fsm == cgt_pkg::ST_DONE && manual ##[1:20] q.fsm == cgt_pkg::ST_OPEN);
endmodule

// File: bench/cgt_src_model.sv
// channel and arming source model standing in front of the gate control
// assumes the bench calls its tasks right after a rising mclk edge
`timescale 1ns/1ps
module cgt_src_model (
  input wire logic mclk_i,
  output logic ch1_o,
  output logic ch2_o,
  output logic arm_o
);
  initial begin
    ch1_o = 1'b0;
    ch2_o = 1'b0;
    arm_o = 1'b0;
  end

  // n channel-one pulses; channel two toggles per pulse, half rate
  task automatic burst(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge mclk_i);
      ch1_o <= 1'b1;
      ch2_o <= ~ch2_o;
      repeat (half) @(posedge mclk_i);
      ch1_o <= 1'b0;
    end
  endtask

  // one high pulse on the arming line
  task automatic arm_pulse(input int len);
    arm_o <= 1'b1;
    repeat (len) @(posedge mclk_i);
    arm_o <= 1'b0;
    @(posedge mclk_i);
  endtask

  // slow pulses only while running totals are sent
endmodule

// File: bench/test_cgt_gate_ctrl.sv
// self-checking bench of the gate control: apb tasks and input bursts
// assumes cgt_pkg and cgt_gate_ctrl compiled first
`timescale 1ns/1ps
module test_cgt_gate_ctrl;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic ch1, ch2, arm;
  logic gate_n_o;
  logic delay_led_o;
  logic [1:0] ops_en_o;
  cgt_pkg::cgt_host_t host_o;
  cgt_pkg::cgt_host_t last;
  int num_errors = 0;
  int tests_run = 0;
  int hcnt = 0;
  int ucnt = 0;
  int h0;
  logic [31:0] rv;
  logic er;

  cgt_gate_ctrl #(.TICK_CYCLES(4)) u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .ch1_i(ch1), .ch2_i(ch2),
    .arm_i(arm), .gate_n_o(gate_n_o), .delay_led_o(delay_led_o), .ops_en_o(ops_en_o), .host_o(host_o));
  cgt_src_model u_src (.mclk_i(mclk_i), .ch1_o(ch1), .ch2_o(ch2), .arm_o(arm));

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // host pulses: all, and untagged ones
  always @(posedge mclk_i) begin
    if (host_o.valid === 1'b1) begin
      hcnt++;
      last = host_o;
      if (host_o.tag === cgt_pkg::TAG_NONE) ucnt++;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    t = 0;
    do begin
      @(posedge mclk_i);
      t++;
    end while (pready_o !== 1'b1 && t < 50);
    rv = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
    if (t >= 50) check("pready", 32'h0, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rv, exp);
  endtask

  task automatic key();
    apb(1'b1, cgt_pkg::OFF_CMD, 32'h1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    rd(cgt_pkg::OFF_CTRL, 32'h0, "ctrl rst");
    rd(cgt_pkg::OFF_GATE, 32'h2710, "gate rst");
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped err", 32'(er), 32'h1);
    apb(1'b1, cgt_pkg::OFF_GATE, 32'h2);
    h0 = hcnt;
    u_src.burst(40, 3);
    check("self armed run", 32'(hcnt > h0), 32'h1);
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h80);
    h0 = hcnt;
    u_src.burst(20, 3);
    check("no arm no gate", 32'(hcnt), 32'(h0));
    u_src.arm_pulse(3);
    u_src.burst(40, 3);
    check("armed run", 32'(hcnt > h0), 32'h1);
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h40);
    rd(cgt_pkg::OFF_CTRL, 32'h48, "close arm single");
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h40);
    rd(cgt_pkg::OFF_CTRL, 32'h40, "mode override");
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h1);
    rd(cgt_pkg::OFF_CTRL, 32'h9, "interval single");
    check("no delay", 32'(delay_led_o), 32'h0);
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h1);
    rd(cgt_pkg::OFF_CTRL, 32'h1, "interval std");
    check("delay led", 32'(delay_led_o), 32'h1);
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h1802);
    rd(cgt_pkg::OFF_CTRL, 32'h180e, "total key");
    check("ops off", 32'(ops_en_o), 32'h0);
    check("gate closed", 32'(gate_n_o), 32'h1);
    key();
    repeat (3) @(posedge mclk_i);
    check("gate open", 32'(gate_n_o), 32'h0);
    u_src.burst(5, 4);
    h0 = hcnt;
    key();
    repeat (4) @(posedge mclk_i);
    check("one result", 32'(hcnt), 32'(h0 + 1));
    check("tag", 32'(last.tag), 32'(cgt_pkg::TAG_CHAR));
    check("total", last.data, 32'h5);
    key();
    u_src.burst(3, 4);
    key();
    rd(cgt_pkg::OFF_RES_A, 32'h8, "reopen adds");
    key();
    u_src.burst(2, 4);
    apb(1'b1, cgt_pkg::OFF_CMD, 32'h2);
    u_src.burst(3, 4);
    key();
    rd(cgt_pkg::OFF_RES_A, 32'h3, "clear open");
    apb(1'b1, cgt_pkg::OFF_CMD, 32'h2);
    rd(cgt_pkg::OFF_RES_A, 32'h0, "clear closed");
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h1806);
    repeat (2) @(posedge mclk_i);
    check("ops on", 32'(ops_en_o), 32'h3);
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h10e);
    h0 = ucnt;
    key();
    u_src.burst(3, 20);
    check("running sent", 32'(ucnt > h0), 32'h1);
    key();
    repeat (4) @(posedge mclk_i);
    check("close tag", 32'(last.tag), 32'(cgt_pkg::TAG_CHAR));
    h0 = ucnt;
    key();
    u_src.burst(2, 20);
    check("reopen sent", 32'(ucnt > h0), 32'h1);
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h3);
    u_src.burst(40, 3);
    apb(1'b0, cgt_pkg::OFF_RES_B, 32'h0);
    check("ratio b counted", 32'(rv != 32'h0), 32'h1);
    rd(cgt_pkg::OFF_RES_A, {rv[30:0], 1'b0}, "ratio a");
    apb(1'b1, cgt_pkg::OFF_CTRL, 32'h1);
    u_src.burst(3, 3);
    rd(cgt_pkg::OFF_RES_A, 32'hc, "interval cycles");
    report_and_stop();
  end
endmodule
